// *** hw/cidec_pkg.sv ***
package cidec_pkg;
   // =====================================================================
   // data space map
   localparam logic [7:0]  SD_BASE     = 8'h80; // four short-direct regs 80h..83h
   localparam logic [5:0]  SD_HI       = 6'h20; // SD_BASE[7:2]
   localparam logic [7:0]  ACC_ADDR    = 8'hFF; // accumulator mirror
   localparam int          STACK_DEPTH = 6;
   localparam int          PC_W        = 12;
   // =====================================================================
   // cycle counts, one clock per machine cycle at 40 MHz
   localparam int          CLK_PER_MC  = 1;
   localparam logic [2:0]  CYC_SHORT   = 3'h2;
   localparam logic [2:0]  CYC_STD     = 3'h4;
   localparam logic [2:0]  CYC_BIT     = 3'h5;
   // =====================================================================
   // opcode groups
   localparam logic [2:0]  GRP_EXT     = 3'h4; // 8xh call, 9xh jump
   localparam logic [2:0]  GRP_BIT     = 3'h5; // Axh..Bxh
   localparam logic [2:0]  GRP_MISC    = 3'h7; // Exh..Fxh
   localparam logic [7:0]  OP_NOP      = 8'h40; // zero branch to next address
   localparam logic [1:0]  ALU_ADD     = 2'h0;
   localparam logic [1:0]  ALU_AND     = 2'h1;
   localparam logic [1:0]  ALU_CP      = 2'h2;
   localparam logic [1:0]  ALU_SUB     = 2'h3;
   // =====================================================================
   // sequencer states, gray along fetch-operand-operand2-read-exec-halt
   typedef enum logic [2:0] {
      ST_FETCH = 3'b000,
      ST_OPND  = 3'b001,
      ST_OPND2 = 3'b011,
      ST_READ  = 3'b010,
      ST_EXEC  = 3'b110,
      ST_HALT  = 3'b100
   } cidec_state_e;
endpackage

// *** hw/cidec_stack_if.sv ***
`timescale 1ns/1ps
interface cidec_stack_if;
   import cidec_pkg::*;
   logic            push;
   logic            pop;
   logic [PC_W-1:0] push_addr;
   logic [PC_W-1:0] top_addr;
   modport core  (output push, output pop, output push_addr, input top_addr);
   modport stack (input push, input pop, input push_addr, output top_addr);
endinterface

// *** hw/cidec_stack.sv ***
`timescale 1ns/1ps
module cidec_stack
   import cidec_pkg::*;
(
   input wire logic   sys_clk,
   input wire logic   rst_n,
   cidec_stack_if.stack stk
);
   logic [PC_W-1:0] ent_q [STACK_DEPTH];

   // =====================================================================
   // shift stack: a seventh push drops the oldest entry, popping empty gives zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            ent_q[i] <= '0;
         end
      end else if (stk.push) begin
         ent_q[0] <= stk.push_addr;
         for (int i = 1; i < STACK_DEPTH; i++) begin
            ent_q[i] <= ent_q[i-1];
         end
      end else if (stk.pop) begin
         for (int i = 0; i < STACK_DEPTH - 1; i++) begin
            ent_q[i] <= ent_q[i+1];
         end
         ent_q[STACK_DEPTH-1] <= '0;
      end
   end

   assign stk.top_addr = ent_q[0];
endmodule

// *** hw/cidec_core.sv ***
`timescale 1ns/1ps
module cidec_core
   import cidec_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            rst_n,
   output logic [PC_W-1:0]      prog_addr,
   input  wire logic [7:0]      prog_rdata,
   output logic [7:0]           data_addr,
   output logic [7:0]           data_wdata,
   output logic                 data_we,
   input  wire logic [7:0]      data_rdata,
   input  wire logic            wdg_sel,
   input  wire logic            int_enter,
   input  wire logic [PC_W-1:0] int_vector,
   input  wire logic            wake,
   output logic [PC_W-1:0]      pc,
   output logic [7:0]           acc,
   output logic                 zero_flag,
   output logic                 carry_flag,
   output logic                 halted_stop,
   output logic                 halted_wait,
   output logic                 illegal_op,
   output logic                 instr_done
);
   // =====================================================================
   // decode functions
   function automatic logic f_valid(input logic [7:0] op);
      return !(op[7:4] == 4'hF && op[3:2] != 2'h0);
   endfunction

   function automatic logic [2:0] f_cycles(input logic [7:0] op);
      if (!op[7] || !f_valid(op))                 return CYC_SHORT;
      else if (op[7:5] == GRP_BIT)                return op[4] ? CYC_STD : CYC_BIT;
      else if (op[7:5] == GRP_MISC && op[4])      return CYC_SHORT;
      else                                        return CYC_STD;
   endfunction

   function automatic logic [1:0] f_bytes(input logic [7:0] op);
      if (!op[7] || op[7:6] == 2'h3 && !op[5])    return 2'h1;
      else if (op[7:5] == GRP_EXT)                return 2'h2;
      else if (op[7:5] == GRP_BIT)                return op[4] ? 2'h2 : 2'h3;
      else if (op[4] || op[3:1] == 3'h7)          return 2'h1;
      else if (op[3:0] == 4'h7)                   return 2'h3;
      else                                        return 2'h2;
   endfunction

   // common micro-op: 0..3 alu, 4 load to acc, 5 store acc, 6 minus one, 7 plus one
   function automatic logic [2:0] f_uop(input logic [7:0] op);
      if (!op[5] && !op[3])  return op[2:0];
      else if (!op[5])       return {1'b1, op[4], op[2]};
      else if (!op[1])       return {1'b0, op[3:2]};
      else                   return {1'b1, op[3:2] == 2'h2, op[0]};
   endfunction

   function automatic logic [8:0] f_alu(input logic [1:0] f, input logic [7:0] a,
                                        input logic [7:0] b);
      case (f)
         ALU_ADD: return {1'b0, a} + {1'b0, b};
         ALU_AND: return {1'b0, a & b};
         default: return {a < b, 8'(a - b)}; // carry marks a borrow
      endcase
   endfunction

   // =====================================================================
   // state
   cidec_state_e    state_q;
   logic [7:0]      op_q, b1_q, b2_q, dat_q, acc_q;
   logic [PC_W-1:0] pc_q;
   logic            z_q, c_q, zs_q, cs_q;
   logic            hstop_q, hwait_q, ill_q, done_q;
   logic [7:0]      sdreg_q [4];
   cidec_stack_if   stk_if ();

   cidec_stack cidec_stack_i (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .stk     (stk_if.stack)
   );

   // =====================================================================
   // opcode classes of the running instruction
   logic            is_rel, is_ext, is_bit, is_misc, is_ctrl, valid, cond, tbit;
   logic [2:0]      uop;
   logic [7:0]      daddr, rd_val, opnd, res_v;
   logic [8:0]      alu;
   logic [PC_W-1:0] pc_v;
   logic            wr_v, acc_en, z_en, c_en, z_v, c_v, push_v, pop_v, stop_v, wait_v;
   logic [7:0]      acc_v;
   logic            sd_hit, acc_hit;

   assign is_rel  = !op_q[7];
   assign is_ext  = op_q[7:5] == GRP_EXT;
   assign is_bit  = op_q[7:5] == GRP_BIT;
   assign is_misc = op_q[7:5] == GRP_MISC;
   assign is_ctrl = is_misc && op_q[4];
   assign valid   = f_valid(op_q);
   assign uop     = f_uop(op_q);
   assign tbit    = dat_q[op_q[2:0]];

   // operand address: pointer, short-direct slot or address byte
   always_comb begin
      if (op_q[7:5] == 3'h6 && !op_q[3]) begin
         daddr = sdreg_q[op_q[4]];
      end else if (op_q[7:5] == 3'h6) begin
         daddr = SD_BASE | {6'h00, op_q[1:0]};
      end else begin
         daddr = b1_q;
      end
   end

   // the four registers and the accumulator are held here, not in data memory
   assign sd_hit  = daddr[7:2] == SD_HI;
   assign acc_hit = daddr == ACC_ADDR;
   assign rd_val  = sd_hit ? sdreg_q[daddr[1:0]] : acc_hit ? acc_q : data_rdata;
   assign opnd    = (is_misc && op_q[0] && !op_q[1]) ? b1_q : dat_q;
   assign alu     = f_alu(uop[1:0], acc_q, opnd);

   always_comb begin
      case (op_q[6:5])
         2'h0:    cond = !z_q;
         2'h1:    cond = !c_q;
         2'h2:    cond = z_q;
         default: cond = c_q;
      endcase
   end

   // =====================================================================
   // execute: result, write target, flags and next address
   always_comb begin
      res_v  = dat_q;
      wr_v   = 1'b0;
      acc_en = 1'b0;
      acc_v  = acc_q;
      z_en   = 1'b0;
      c_en   = 1'b0;
      z_v    = z_q;
      c_v    = c_q;
      push_v = 1'b0;
      pop_v  = 1'b0;
      stop_v = 1'b0;
      wait_v = 1'b0;
      pc_v   = pc_q + PC_W'(f_bytes(op_q));
      if (is_rel) begin
         if (cond && !op_q[4]) begin
            pc_v = pc_q + 12'h001 + {8'h00, op_q[3:0]};
         end else if (cond) begin
            pc_v = pc_q - {8'h00, op_q[3:0]};
         end
      end else if (is_ext) begin
         pc_v   = {op_q[3:0], b1_q};
         push_v = !op_q[4];
      end else if (is_bit && !op_q[4]) begin
         c_en = 1'b1;
         c_v  = tbit;
         if (tbit == op_q[3]) begin
            pc_v = pc_q + 12'h002 + {{4{b2_q[7]}}, b2_q};
         end
      end else if (is_bit) begin
         wr_v  = 1'b1;
         res_v = dat_q;
         res_v[op_q[2:0]] = !op_q[3];
      end else if (!valid) begin
         pc_v = pc_q + 12'h001;
      end else if (is_ctrl) begin
         case (op_q[1:0])
            2'h0:    pop_v = 1'b1;
            2'h1: begin
               pop_v = 1'b1;
               z_en  = 1'b1;
               c_en  = 1'b1;
               z_v   = zs_q;
               c_v   = cs_q;
            end
            2'h2: begin
               stop_v = !wdg_sel;
               wait_v = wdg_sel;
            end
            default: wait_v = 1'b1;
         endcase
         if (pop_v) begin
            pc_v = stk_if.top_addr;
         end
      end else if (is_misc && op_q[3:1] == 3'h3) begin
         if (op_q[0]) begin
            wr_v  = 1'b1;
            res_v = b2_q;
         end else begin
            acc_en = 1'b1;
            acc_v  = b1_q;
            z_en   = 1'b1;
            z_v    = b1_q == 8'h00;
         end
      end else if (is_misc && op_q[3:1] == 3'h7) begin
         acc_en = 1'b1;
         c_en   = 1'b1;
         c_v    = acc_q[7];
         acc_v  = op_q[0] ? {acc_q[6:0], c_q} : ~acc_q;
         z_en   = 1'b1;
         z_v    = acc_v == 8'h00;
      end else begin
         z_en = 1'b1;
         case (uop)
            3'h4: begin
               acc_en = 1'b1;
               acc_v  = dat_q;
               z_v    = dat_q == 8'h00;
            end
            3'h5: begin
               wr_v  = 1'b1;
               res_v = acc_q;
               z_v   = acc_q == 8'h00;
            end
            3'h6, 3'h7: begin
               wr_v  = 1'b1;
               res_v = uop[0] ? 8'(dat_q + 8'h01) : 8'(dat_q - 8'h01);
               z_v   = res_v == 8'h00;
            end
            default: begin
               acc_en = uop[1:0] != ALU_CP;
               acc_v  = alu[7:0];
               c_en   = 1'b1;
               c_v    = alu[8];
               z_v    = alu[7:0] == 8'h00;
            end
         endcase
      end
      if (wr_v && acc_hit) begin
         acc_en = 1'b1;
         acc_v  = res_v;
      end
   end

   // =====================================================================
   // sequencer: each state is one machine cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_FETCH;
      end else begin
         case (state_q)
            ST_FETCH: begin
               if (!int_enter) begin
                  state_q <= (f_cycles(prog_rdata) == CYC_SHORT) ? ST_EXEC : ST_OPND;
               end
            end
            ST_OPND:  state_q <= (f_cycles(op_q) == CYC_BIT) ? ST_OPND2 : ST_READ;
            ST_OPND2: state_q <= ST_READ;
            ST_READ:  state_q <= ST_EXEC;
            ST_EXEC:  state_q <= (stop_v || wait_v) ? ST_HALT : ST_FETCH;
            ST_HALT:  state_q <= wake ? ST_FETCH : ST_HALT;
            default:  state_q <= ST_FETCH;
         endcase
      end
   end

   // instruction bytes and operand capture
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q  <= OP_NOP;
         b1_q  <= '0;
         b2_q  <= '0;
         dat_q <= '0;
      end else begin
         if (state_q == ST_FETCH) op_q <= prog_rdata;
         if (state_q == ST_OPND) b1_q <= prog_rdata;
         if (state_q == ST_OPND2 || state_q == ST_READ) b2_q <= prog_rdata;
         if (state_q == ST_READ) dat_q <= rd_val;
      end
   end

   // program counter, interrupt entry saves flags for the interrupt exit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= '0;
         zs_q <= 1'b0;
         cs_q <= 1'b0;
      end else if (state_q == ST_FETCH && int_enter) begin
         pc_q <= int_vector;
         zs_q <= z_q;
         cs_q <= c_q;
      end else if (state_q == ST_EXEC) begin
         pc_q <= pc_v;
      end
   end

   // accumulator, flags and short-direct registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= '0;
         z_q   <= 1'b0;
         c_q   <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            sdreg_q[i] <= '0;
         end
      end else if (state_q == ST_EXEC) begin
         if (acc_en) acc_q <= acc_v;
         if (z_en) z_q <= z_v;
         if (c_en) c_q <= c_v;
         if (wr_v && sd_hit) sdreg_q[daddr[1:0]] <= res_v;
      end
   end

   // halt status and completion pulses
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hstop_q <= 1'b0;
         hwait_q <= 1'b0;
         ill_q   <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         done_q <= state_q == ST_EXEC;
         ill_q  <= state_q == ST_EXEC && !valid;
         if (state_q == ST_EXEC) begin
            hstop_q <= stop_v;
            hwait_q <= wait_v;
         end else if (state_q == ST_HALT && wake) begin
            hstop_q <= 1'b0;
            hwait_q <= 1'b0;
         end
      end
   end

   // =====================================================================
   // memory ports; addresses are combinational so reads finish in-cycle
   always_comb begin
      case (state_q)
         ST_FETCH: prog_addr = pc_q;
         ST_OPND:  prog_addr = pc_q + 12'h001;
         default:  prog_addr = pc_q + 12'h002;
      endcase
   end

   assign data_addr  = daddr;
   assign data_wdata = res_v;
   assign data_we    = state_q == ST_EXEC && wr_v && !sd_hit && !acc_hit;

   assign stk_if.push      = (state_q == ST_EXEC && push_v) || (state_q == ST_FETCH && int_enter);
   assign stk_if.pop       = state_q == ST_EXEC && pop_v;
   assign stk_if.push_addr = (state_q == ST_FETCH) ? pc_q : pc_q + 12'h002;

   assign pc          = pc_q;
   assign acc         = acc_q;
   assign zero_flag   = z_q;
   assign carry_flag  = c_q;
   assign halted_stop = hstop_q;
   assign halted_wait = hwait_q;
   assign illegal_op  = ill_q;
   assign instr_done  = done_q;
endmodule

// *** tb/cidec_core_checker.sv ***
`timescale 1ns/1ps
// ==================================================================
// port checks for the core
module cidec_core_checker
   import cidec_pkg::*;
(
   input wire logic            sys_clk,
   input wire logic            rst_n,
   input wire logic [PC_W-1:0] prog_addr,
   input wire logic [7:0]      data_addr,
   input wire logic            data_we,
   input wire logic            wdg_sel,
   input wire logic            wake,
   input wire logic [PC_W-1:0] pc,
   input wire logic [7:0]      acc,
   input wire logic            zero_flag,
   input wire logic            carry_flag,
   input wire logic            halted_stop,
   input wire logic            halted_wait,
   input wire logic            illegal_op,
   input wire logic            instr_done
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ==================================================================
   // bus and sequencing relations; state may only move when a step ends
   AST_WE_INTERNAL: assert property (
      data_we |-> data_addr[7:2] != SD_HI && data_addr != ACC_ADDR)
      else $error("write reached an internal location");
   AST_WE_SPACING: assert property (data_we |=> !data_we)
      else $error("back to back data writes");
   AST_WE_THEN_DONE: assert property (data_we |=> instr_done)
      else $error("write not in the last cycle of a step");
   AST_DONE_GAP: assert property (instr_done |=> !instr_done)
      else $error("step shorter than two cycles");
   AST_ILLEGAL_DONE: assert property (illegal_op |-> instr_done)
      else $error("illegal flag outside a step end");
   AST_STATE_AT_DONE: assert property (
      ($changed(acc) || $changed(zero_flag) || $changed(carry_flag)) |-> instr_done)
      else $error("state changed mid step");
   AST_FETCH_AT_PC: assert property (
      instr_done && !halted_stop && !halted_wait |-> prog_addr == pc)
      else $error("next fetch not at pc");
   AST_STOP_WDG: assert property ($rose(halted_stop) |-> !$past(wdg_sel))
      else $error("stop taken with watchdog selected");
   AST_WAKE_LEAVES: assert property (
      (halted_stop || halted_wait) && wake |=> !halted_stop && !halted_wait)
      else $error("wake did not leave halt");
endmodule

bind cidec_core cidec_core_checker cidec_core_checker_i (
   .sys_clk, .rst_n, .prog_addr, .data_addr, .data_we, .wdg_sel, .wake, .pc, .acc,
   .zero_flag, .carry_flag, .halted_stop, .halted_wait, .illegal_op, .instr_done);

// *** tb/cidec_mem.sv ***
`timescale 1ns/1ps
// ==================================================================
// program and data space around the core
module cidec_mem
   import cidec_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic [PC_W-1:0] prog_addr,
   output logic [7:0]           prog_rdata,
   input  wire logic [7:0]      data_addr,
   input  wire logic [7:0]      data_wdata,
   input  wire logic            data_we,
   output logic [7:0]           data_rdata
);
   logic [7:0] pmem   [0:4095];
   logic [7:0] dmem_q [0:255];
   // zero latency reads; internal places answer inverted so misuse shows
   assign prog_rdata = pmem[prog_addr];
   assign data_rdata = (data_addr[7:2] == SD_HI || data_addr == ACC_ADDR) ?
                       ~dmem_q[data_addr] : dmem_q[data_addr];
   // plain always so the bench may preload cells
   always @(posedge sys_clk) begin
      if (data_we) begin
         dmem_q[data_addr] <= data_wdata;
      end
   end
endmodule

// *** tb/cidec_core_tb.sv ***
`timescale 1ns/1ps
module cidec_core_tb
   import cidec_pkg::*;
;
   logic            sys_clk = 1'b0;
   logic            rst_n = 1'b0;
   logic            wdg_sel = 1'b0;
   logic            int_enter = 1'b0;
   logic            wake = 1'b0;
   logic [PC_W-1:0] int_vector = 12'h000;
   logic [PC_W-1:0] prog_addr, pc;
   logic [7:0]      prog_rdata, data_addr, data_wdata, data_rdata, acc;
   logic            data_we, zero_flag, carry_flag, halted_stop, halted_wait;
   logic            illegal_op, instr_done;
   int              bad_count = 0;
   int              comparisons = 0;
   int              cycles = 0;

   cidec_core cidec_core_i (.sys_clk, .rst_n, .prog_addr, .prog_rdata, .data_addr,
      .data_wdata, .data_we, .data_rdata, .wdg_sel, .int_enter, .int_vector, .wake,
      .pc, .acc, .zero_flag, .carry_flag, .halted_stop, .halted_wait, .illegal_op,
      .instr_done);
   cidec_mem cidec_mem_i (.sys_clk, .prog_addr, .prog_rdata, .data_addr, .data_wdata,
      .data_we, .data_rdata);

   always #12.5 sys_clk = ~sys_clk;
   // hang guard; the full run needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end
   // ==================================================================
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic put(input logic [11:0] a, input logic [7:0] b[$]);
      foreach (b[i]) cidec_mem_i.pmem[a + i] = b[i];
   endtask
   // reset and fill program space with no-ops
   task automatic clear();
      rst_n = 1'b0;
      foreach (cidec_mem_i.pmem[i]) cidec_mem_i.pmem[i] = OP_NOP;
   endtask
   // wait for the next step end; cyc of zero skips the gap compare
   task automatic step(input int cyc, input logic [11:0] p, input logic [7:0] a,
                       input logic [1:0] zc);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (instr_done !== 1'b1 && n < 60);
      check(instr_done, 1'b1);
      if (cyc > 0) check(n, cyc);
      check(pc, p);
      check(acc, a);
      check({zero_flag, carry_flag}, zc);
   endtask
   task automatic go();
      repeat (2) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      step(0, 12'h001, 8'h00, 2'h0);
      check(illegal_op, 1'b0);
   endtask
   // ==================================================================
   // scenarios
   task automatic t_load();
      clear();
      cidec_mem_i.dmem_q[8'h20] = 8'h77;
      put(12'h000, {8'h40, 8'hE6, 8'h05, 8'hE1, 8'hFB, 8'hE3, 8'h20, 8'hE7, 8'h30,
                    8'hAA, 8'hE2, 8'h30, 8'hED, 8'hAB});
      go();
      step(4, 12'h003, 8'h05, 2'h0);
      step(4, 12'h005, 8'h00, 2'h3);
      step(4, 12'h007, 8'h00, 2'h3);
      check(cidec_mem_i.dmem_q[8'h20], 8'h00);
      step(4, 12'h00A, 8'h00, 2'h3);
      check(cidec_mem_i.dmem_q[8'h30], 8'hAA);
      step(4, 12'h00C, 8'hAA, 2'h1);
      step(4, 12'h00E, 8'hFF, 2'h1);
      $display("load test done");
   endtask
   task automatic t_acc();
      clear();
      cidec_mem_i.dmem_q[8'h40] = 8'h01;
      put(12'h000, {8'h40, 8'hE6, 8'h81, 8'hEF, 8'hEE, 8'hE9, 8'hFD, 8'hE5, 8'h8F,
                    8'hE0, 8'hFF, 8'hEA, 8'h40, 8'hEB, 8'h40});
      go();
      step(4, 12'h003, 8'h81, 2'h0);
      step(4, 12'h004, 8'h02, 2'h1);
      step(4, 12'h005, 8'hFD, 2'h0);
      step(4, 12'h007, 8'hFD, 2'h2);
      step(4, 12'h009, 8'h8D, 2'h0);
      step(4, 12'h00B, 8'h1A, 2'h1);
      step(4, 12'h00D, 8'h1A, 2'h3);
      check(cidec_mem_i.dmem_q[8'h40], 8'h00);
      step(4, 12'h00F, 8'h1A, 2'h1);
      check(cidec_mem_i.dmem_q[8'h40], 8'h01);
      $display("accumulator test done");
   endtask
   task automatic t_branch();
      clear();
      put(12'h000, {8'h40, 8'hE6, 8'h00, 8'h4F});
      put(12'h005, {8'h1F, 8'h21});
      put(12'h013, {8'h7F, 8'h5F});
      go();
      step(4, 12'h003, 8'h00, 2'h2);
      step(2, 12'h013, 8'h00, 2'h2);
      step(2, 12'h014, 8'h00, 2'h2);
      step(2, 12'h005, 8'h00, 2'h2);
      step(2, 12'h006, 8'h00, 2'h2);
      step(2, 12'h008, 8'h00, 2'h2);
      $display("branch test done");
   endtask
   task automatic t_bits();
      clear();
      cidec_mem_i.dmem_q[8'h50] = 8'h00;
      put(12'h000, {8'h40, 8'hB7, 8'h50, 8'hAF, 8'h50, 8'h7F});
      put(12'h084, {8'hBF, 8'h50, 8'hA7, 8'h50, 8'h80});
      put(12'h008, {8'hA8, 8'h50, 8'h00});
      go();
      step(4, 12'h003, 8'h00, 2'h0);
      check(cidec_mem_i.dmem_q[8'h50], 8'h80);
      step(5, 12'h084, 8'h00, 2'h1);
      step(4, 12'h086, 8'h00, 2'h1);
      check(cidec_mem_i.dmem_q[8'h50], 8'h00);
      step(5, 12'h008, 8'h00, 2'h0);
      step(5, 12'h00B, 8'h00, 2'h0);
      $display("bit test done");
   endtask
   task automatic t_jump();
      clear();
      int_vector = 12'h200;
      put(12'h000, {8'h40, 8'h8A, 8'hBC, 8'h9F, 8'h00});
      put(12'hABC, {8'hF0});
      put(12'h200, {8'hE6, 8'h00, 8'hF1});
      go();
      step(4, 12'hABC, 8'h00, 2'h0);
      step(2, 12'h003, 8'h00, 2'h0);
      step(4, 12'hF00, 8'h00, 2'h0);
      step(2, 12'hF01, 8'h00, 2'h0);
      int_enter = 1'b1;
      @(posedge sys_clk);
      #1 int_enter = 1'b0;
      step(0, 12'h202, 8'h00, 2'h2);
      step(2, 12'hF01, 8'h00, 2'h0);
      $display("jump test done");
   endtask
   // one halting step, then a wake pulse
   task automatic halt_case(input int cyc, input logic ws, input logic [11:0] p,
                            input logic es);
      wdg_sel = ws;
      step(cyc, p, 8'h00, 2'h0);
      check({halted_stop, halted_wait}, {es, ~es});
      repeat (3) @(posedge sys_clk);
      #1 check(pc, p);
      wake = 1'b1;
      @(posedge sys_clk);
      #1 wake = 1'b0;
      check({halted_stop, halted_wait}, 2'h0);
   endtask
   task automatic t_halt();
      clear();
      put(12'h000, {8'h40, 8'hF2, 8'hF2, 8'hF3});
      go();
      halt_case(2, 1'b0, 12'h002, 1'b1);
      halt_case(0, 1'b1, 12'h003, 1'b0);
      halt_case(0, 1'b0, 12'h004, 1'b0);
      $display("halt test done");
   endtask
   task automatic t_illegal();
      clear();
      for (int i = 0; i < 12; i++) cidec_mem_i.pmem[i + 1] = 8'hF4 + 8'(i);
      go();
      for (int i = 0; i < 12; i++) begin
         step(2, 12'(i + 2), 8'h00, 2'h0);
         check(illegal_op, 1'h1);
      end
      $display("undefined opcode test done");
   endtask
   task automatic t_short();
      clear();
      cidec_mem_i.dmem_q[8'h00] = 8'h5A;
      cidec_mem_i.dmem_q[8'h42] = 8'h00;
      put(12'h000, {8'h40, 8'hE6, 8'h42, 8'hCD, 8'hD5, 8'hC4, 8'hDF, 8'hCB,
                    8'hC6, 8'hEC, 8'h00, 8'h62});
      go();
      step(4, 12'h003, 8'h42, 2'h0);
      step(4, 12'h004, 8'h42, 2'h0);
      step(4, 12'h005, 8'h42, 2'h0);
      check(cidec_mem_i.dmem_q[8'h42], 8'h42);
      step(4, 12'h006, 8'h5A, 2'h0);
      step(4, 12'h007, 8'h5A, 2'h0);
      step(4, 12'h008, 8'h01, 2'h0);
      step(4, 12'h009, 8'h01, 2'h0);
      check(cidec_mem_i.dmem_q[8'h00], 8'h59);
      step(4, 12'h00B, 8'hA8, 2'h1);
      step(2, 12'h00E, 8'hA8, 2'h1);
      $display("register test done");
   endtask
   // ==================================================================
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      t_load();
      t_acc();
      t_branch();
      t_bits();
      t_jump();
      t_halt();
      t_illegal();
      t_short();
      report_and_stop();
   end
endmodule
